// file: bench/aesr_assertions.sv
// Port-level checker of the serial position readout.
// Assumes binding to aesr_top; all pins settle within a few aclk edges.
`timescale 1ns/10ps
module aesr_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Link and optical inputs
  input wire logic load_shift_select,
  input wire logic shift_clock,
  input wire logic serial_data_out,
  input wire logic correction_select,
  input wire logic direction_invert,
  input wire logic [aesr_pkg::TRACK_W-1:0] track_bits,
  input wire logic sine_comparator,
  input wire logic cosine_comparator,
  input wire logic low_light,
  input wire logic led_overdrive,
  // Status pins
  input wire logic light_alarm,
  input wire logic digitized_sine_bit,
  input wire logic cosine_test_output
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_alarm_follows: assert property ((low_light && led_overdrive)[*4] |=> light_alarm)
    else $error("light alarm not raised");
  a_sine_copy: assert property (sine_comparator[*4] |=> digitized_sine_bit)
    else $error("sine test output wrong");
  a_cosine_copy: assert property (!cosine_comparator[*4] |=> !cosine_test_output)
    else $error("cosine test output wrong");
  a_load_msb: assert property ((load_shift_select && !correction_select && $stable(track_bits[10])
    && $stable(direction_invert))[*7] |-> serial_data_out == (track_bits[10] ^ direction_invert))
    else $error("load mode head bit wrong");
  a_shift_hold: assert property ((!load_shift_select && !$rose(shift_clock))[*6] |-> $stable(serial_data_out))
    else $error("output moved without shift edge");
  a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read data late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
endmodule
bind aesr_top aesr_assertions i_aesr_assertions (.*);

// file: bench/aesr_reader.sv
// Serial reader standing at the far side of the position link.
// Assumes its own shift clock timing, unrelated to aclk; clock idles high.
`timescale 1ns/10ps
module aesr_reader (
  // Link pins
  output logic load_shift_select,
  output logic shift_clock,
  input wire logic serial_data_out
);
  initial begin
    load_shift_select = 1'h1;
    shift_clock = 1'h1;
  end
  // Load, then n pulses of 160 ns; one sample at each falling edge
  task automatic read_word(input int n, output logic [31:0] bits);
    bits = 32'h0000_0000;
    load_shift_select = 1'h1;
    #247;
    load_shift_select = 1'h0;
    // Shift edges land midway between aclk edges
    #88;
    for (int k = 0; k < n; k++) begin
      bits = {bits[30:0], serial_data_out};
      shift_clock = 1'h0;
      #80;
      shift_clock = 1'h1;
      #80;
    end
    #40;
    load_shift_select = 1'h1;
  endtask
endmodule

// file: bench/test_absolute_encoder_serial_readout.sv
// Self-checking bench of the serial position readout.
// Assumes the reader model aesr_reader and the bound checker.
`timescale 1ns/10ps
module test_absolute_encoder_serial_readout;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, interp_bits = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, serial_in = 1'h0, correction_select = 1'h0, direction_invert = 1'h0;
  logic sine_comparator = 1'h0, cosine_comparator = 1'h0, low_light = 1'h0, led_overdrive = 1'h0;
  logic probe_enable = 1'h0, factory_probe_clock = 1'h0, calibration_trigger = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic load_shift_select, shift_clock, serial_data_out, light_alarm, digitized_sine_bit, cosine_test_output;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [10:0] track_bits = 11'h000;
  logic [31:0] rnd = 32'h0000_3eeb;
  logic serin_on = 1'h1;
  int mismatches = 0, n_tests = 0, cycles = 0;

  aesr_top i_aesr_top (.*);
  aesr_reader i_aesr_reader (.*);

  always #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    rnd = xs(rnd);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awprot <= rnd[2:0];
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    rnd = xs(rnd);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= rnd[2:0];
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Random position, one frame, compared with the word model
  task automatic frame(input int n, input logic corr);
    logic [31:0] got, e;
    logic [15:0] w;
    logic [10:0] b;
    rnd = xs(rnd);
    @(posedge aclk);
    track_bits <= rnd[10:0];
    sine_comparator <= rnd[11];
    interp_bits <= rnd[15:12];
    direction_invert <= rnd[16];
    serial_in <= rnd[17];
    cosine_comparator <= rnd[18];
    correction_select <= corr;
    @(posedge aclk);
    // Tracks to binary, stepped onto the quadrature edge when corrected
    b = track_bits;
    for (int k = 9; k >= 0; k--) b[k] = b[k+1] ^ track_bits[k];
    if (corr && b[0] != cosine_comparator && !sine_comparator) begin
      b = cosine_comparator ? b - 11'h001 : b + 11'h001;
    end
    b = b ^ (b >> 1);
    w = {b[10] ^ direction_invert, b[9:0], sine_comparator, interp_bits};
    e = 32'h0000_0000;
    for (int k = 0; k < n; k++) e = {e[30:0], (k < 16) ? w[15 - k] : (serial_in & serin_on)};
    i_aesr_reader.read_word(n, got);
    chk(got, e);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(aesr_pkg::OFF_PIN_EN, rd, rsp);
    chk(rd, 32'h0000_003f);
    axi_rd(aesr_pkg::OFF_IRQ_MASK, rd, rsp);
    chk(rd, 32'h0000_0000);
    axi_rd(8'h40, rd, rsp);
    chk({30'h0, rsp}, {30'h0, aesr_pkg::RESP_SLVERR});
    axi_wr(8'h40, 32'h0000_0001, rsp);
    chk({30'h0, rsp}, {30'h0, aesr_pkg::RESP_SLVERR});
    for (int i = 0; i < 6; i++) frame(16, 1'h0);
    frame(12, 1'h0);
    frame(15, 1'h0);
    repeat (4) frame(16, 1'h1);
    axi_rd(aesr_pkg::OFF_IRQ_STATUS, rd, rsp);
    axi_wr(aesr_pkg::OFF_IRQ_MASK, 32'h0000_000f, rsp);
    chk({30'h0, rsp}, {30'h0, aesr_pkg::RESP_OKAY});
    chk({31'h0, irq}, 32'h0000_0000);
    frame(20, 1'h0);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_rd(aesr_pkg::OFF_IRQ_STATUS, rd, rsp);
    chk(rd, 32'h0000_000d);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_wr(aesr_pkg::OFF_PIN_EN, 32'h0000_001f, rsp);
    serin_on = 1'h0;
    frame(20, 1'h0);
    axi_wr(aesr_pkg::OFF_PIN_EN, 32'h0000_003f, rsp);
    axi_wr(aesr_pkg::OFF_IRQ_MASK, 32'h0000_0002, rsp);
    axi_rd(aesr_pkg::OFF_IRQ_STATUS, rd, rsp);
    @(posedge aclk);
    low_light <= 1'h1;
    led_overdrive <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({31'h0, light_alarm}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_rd(aesr_pkg::OFF_IRQ_STATUS, rd, rsp);
    chk(rd, 32'h0000_0002);
    low_light <= 1'h0;
    repeat (8) @(posedge aclk);
    chk({31'h0, light_alarm}, 32'h0000_0000);
    chk({30'h0, cosine_test_output, digitized_sine_bit}, {30'h0, cosine_comparator, sine_comparator});
    end_of_test();
  end
endmodule

// file: core/aesr_gray.sv
// Composes the 16-bit Gray position word from tracks, quadrature and interpolation.
// Assumes inputs already synchronised to aclk.
`timescale 1ns/10ps
module aesr_gray (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Position assembly
  aesr_pos_if.composer pos
);

  function automatic logic [aesr_pkg::TRACK_W-1:0] gray_to_bin(input logic [aesr_pkg::TRACK_W-1:0] g);
    logic [aesr_pkg::TRACK_W-1:0] b;
    b[aesr_pkg::TRACK_W-1] = g[aesr_pkg::TRACK_W-1];
    for (int i = aesr_pkg::TRACK_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [aesr_pkg::TRACK_W-1:0] bin_to_gray(input logic [aesr_pkg::TRACK_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  wire [aesr_pkg::TRACK_W-1:0] coarse_bin;
  wire [1:0] quad_phase;
  wire mismatch;
  wire [aesr_pkg::TRACK_W-1:0] adj_bin;
  wire [aesr_pkg::TRACK_W-1:0] coarse_gray;
  wire [aesr_pkg::WORD_W-1:0] word_next;

  // Quadrature phase in binary: cosine is the high bit
  assign coarse_bin = gray_to_bin(pos.track);
  assign quad_phase = {pos.cosine, pos.cosine ^ pos.sine};
  assign mismatch = coarse_bin[0] != pos.cosine;
  // Tracks switched early or late: pull them onto the quadrature edge
  assign adj_bin = !(pos.correct && mismatch) ? coarse_bin :
                   (quad_phase == 2'h0) ? coarse_bin + 11'h001 :
                   (quad_phase == 2'h3) ? coarse_bin - 11'h001 : coarse_bin;
  assign coarse_gray = bin_to_gray(adj_bin);
  // Interpolated bits appended untouched
  assign word_next = {coarse_gray[aesr_pkg::TRACK_W-1] ^ pos.invert,
                      coarse_gray[aesr_pkg::TRACK_W-2:0], pos.sine, pos.interp};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos.word <= '0;
    end else begin
      pos.word <= word_next;
    end
  end

endmodule

// file: core/aesr_pkg.sv
// Constants, register map and event layout of the serial position readout.
// Assumes a 50 MHz aclk and an AXI4-Lite master with 32-bit data.
package aesr_pkg;

  localparam int WORD_W = 16;
  localparam int TRACK_W = 11;
  localparam int INTERP_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 5;
  localparam int EVT_W = 4;
  localparam int PIN_W = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_PIN_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_POSITION = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_LINK_STATE = 8'h10;

  // Pin enable bit positions
  localparam int PIN_CORRECT = 0;
  localparam int PIN_PROBE = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_SCLK = 3;
  localparam int PIN_INVERT = 4;
  localparam int PIN_SERIN = 5;

  // Values seen when a pin is released to its pull; reset values of pin enable and interrupt mask
  localparam logic [PIN_W-1:0] PULL_DEFAULT = 6'h0D;
  localparam logic [PIN_W-1:0] PIN_EN_RESET = 6'h3F;
  localparam logic [EVT_W-1:0] IRQ_MASK_RESET = 4'h0;

  // Event bit positions
  localparam int EVT_WORD_DONE = 0;
  localparam int EVT_ALARM = 1;
  localparam int EVT_EXTRA_CLK = 2;
  localparam int EVT_SNAPSHOT = 3;

  localparam logic [CNT_W-1:0] FULL_WORD_CNT = 5'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchroniser width: 6 controls, factory pair, alarm pair, tracks, quadrature, interpolation
  localparam int SYNC_W = PIN_W + 2 + 2 + TRACK_W + 2 + INTERP_W;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 27'h000_000D;

endpackage

// file: core/aesr_pos_if.sv
// Position word assembly signals between readout top and Gray composer.
// Assumes both ends run on aclk.
`timescale 1ns/10ps
interface aesr_pos_if;
  logic [aesr_pkg::TRACK_W-1:0] track;
  logic sine;
  logic cosine;
  logic [aesr_pkg::INTERP_W-1:0] interp;
  logic correct;
  logic invert;
  logic [aesr_pkg::WORD_W-1:0] word;

  modport composer (
    input track, sine, cosine, interp, correct, invert,
    output word
  );
  modport user (
    output track, sine, cosine, interp, correct, invert,
    input word
  );
endinterface

// file: core/aesr_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to aclk; bits are independent levels.
`timescale 1ns/10ps
module aesr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= RST;
      sync_out <= RST;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: core/aesr_top.sv
// Serial readout of the absolute position word with an AXI4-Lite status port.
// Assumes all pins are asynchronous to aclk; shift clock well below aclk/4.
`timescale 1ns/10ps
module aesr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [aesr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [aesr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [aesr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [aesr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link pins
  input wire logic load_shift_select,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_data_out,
  // Static control pins
  input wire logic correction_select,
  input wire logic direction_invert,
  input wire logic probe_enable,
  input wire logic factory_probe_clock,
  input wire logic calibration_trigger,
  // Digitised optical channels
  input wire logic [aesr_pkg::TRACK_W-1:0] track_bits,
  input wire logic sine_comparator,
  input wire logic cosine_comparator,
  input wire logic [aesr_pkg::INTERP_W-1:0] interp_bits,
  // Illumination monitor
  input wire logic low_light,
  input wire logic led_overdrive,
  // Status pins
  output logic light_alarm,
  output logic digitized_sine_bit,
  output logic cosine_test_output,
  output logic irq
);

  function automatic logic reg_hit(input logic [aesr_pkg::ADDR_W-1:0] addr,
                                   input logic [aesr_pkg::ADDR_W-1:0] off);
    return addr[aesr_pkg::ADDR_W-1:2] == off[aesr_pkg::ADDR_W-1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  wire [aesr_pkg::SYNC_W-1:0] pins_raw;
  wire [aesr_pkg::SYNC_W-1:0] pins_sync;
  wire [aesr_pkg::PIN_W-1:0] ctl_sync;
  wire [aesr_pkg::PIN_W-1:0] ctl_eff;
  wire factory_clk_s;
  wire calib_s;
  wire low_light_s;
  wire overdrive_s;
  wire [aesr_pkg::TRACK_W-1:0] track_s;
  wire sine_s;
  wire cosine_s;
  wire [aesr_pkg::INTERP_W-1:0] interp_s;
  logic [aesr_pkg::PIN_W-1:0] pin_en_reg;

  assign pins_raw = {interp_bits, cosine_comparator, sine_comparator, track_bits,
                     led_overdrive, low_light, calibration_trigger, factory_probe_clock,
                     serial_in, direction_invert, shift_clock, load_shift_select,
                     probe_enable, correction_select};

  aesr_sync #(
    .W(aesr_pkg::SYNC_W),
    .RST(aesr_pkg::SYNC_RESET)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign {interp_s, cosine_s, sine_s, track_s, overdrive_s, low_light_s,
          calib_s, factory_clk_s, ctl_sync} = pins_sync;

  // Released pins read their pull level
  generate
    for (genvar i = 0; i < aesr_pkg::PIN_W; i++) begin : g_pull
      assign ctl_eff[i] = pin_en_reg[i] ? ctl_sync[i] : aesr_pkg::PULL_DEFAULT[i];
    end
  endgenerate

  wire load_mode;
  wire sclk_lvl;
  wire ser_in_lvl;

  assign load_mode = ctl_eff[aesr_pkg::PIN_LOAD];
  assign sclk_lvl = ctl_eff[aesr_pkg::PIN_SCLK];
  assign ser_in_lvl = ctl_eff[aesr_pkg::PIN_SERIN];

  ////////////////////////////////////////////////////////////////////////////
  // Position word

  aesr_pos_if pos ();

  assign pos.track = track_s;
  assign pos.sine = sine_s;
  assign pos.cosine = cosine_s;
  assign pos.interp = interp_s;
  assign pos.correct = ctl_eff[aesr_pkg::PIN_CORRECT];
  assign pos.invert = ctl_eff[aesr_pkg::PIN_INVERT];

  aesr_gray u_gray (
    .aclk(aclk),
    .aresetn(aresetn),
    .pos(pos)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shift register

  logic [aesr_pkg::WORD_W-1:0] shreg_reg;
  logic [aesr_pkg::WORD_W-1:0] shreg_next;
  logic sclk_d_reg;
  logic load_d_reg;
  logic [aesr_pkg::CNT_W-1:0] bit_cnt_reg;
  logic [aesr_pkg::CNT_W-1:0] bit_cnt_next;
  wire sclk_rise;
  wire snapshot_evt;
  wire word_done_evt;
  wire extra_clk_evt;

  assign sclk_rise = sclk_lvl && !sclk_d_reg;
  assign snapshot_evt = load_d_reg && !load_mode;
  assign word_done_evt = !load_mode && sclk_rise && bit_cnt_reg == aesr_pkg::FULL_WORD_CNT - 5'h01;
  assign extra_clk_evt = !load_mode && sclk_rise && bit_cnt_reg == aesr_pkg::FULL_WORD_CNT;

  // Load follows the live word; shift moves one place per rising edge
  assign shreg_next = load_mode ? pos.word :
                      sclk_rise ? {shreg_reg[aesr_pkg::WORD_W-2:0], ser_in_lvl} :
                      shreg_reg;
  assign bit_cnt_next = load_mode ? '0 :
                        (sclk_rise && bit_cnt_reg != aesr_pkg::FULL_WORD_CNT) ? bit_cnt_reg + 5'h01 :
                        bit_cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_reg <= '0;
      sclk_d_reg <= 1'b1;
      load_d_reg <= 1'b1;
      bit_cnt_reg <= '0;
    end else begin
      shreg_reg <= shreg_next;
      sclk_d_reg <= sclk_lvl;
      load_d_reg <= load_mode;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  assign serial_data_out = shreg_reg[aesr_pkg::WORD_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Alarm and test outputs

  logic light_alarm_reg;
  logic sine_out_reg;
  logic cosine_out_reg;
  wire alarm_rise_evt;

  assign alarm_rise_evt = low_light_s && overdrive_s && !light_alarm_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      light_alarm_reg <= 1'b0;
      sine_out_reg <= 1'b0;
      cosine_out_reg <= 1'b0;
    end else begin
      light_alarm_reg <= low_light_s && overdrive_s;
      sine_out_reg <= sine_s;
      cosine_out_reg <= cosine_s;
    end
  end

  assign light_alarm = light_alarm_reg;
  assign digitized_sine_bit = sine_out_reg;
  assign cosine_test_output = cosine_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic aw_held_reg;
  logic w_held_reg;
  logic [aesr_pkg::ADDR_W-1:0] awaddr_reg;
  logic [aesr_pkg::DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [aesr_pkg::EVT_W-1:0] mask_reg;
  wire aw_fire;
  wire w_fire;
  wire wr_go;
  wire wr_pin_en;
  wire wr_mask;
  wire wr_mapped;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_held_reg && w_held_reg;
  assign wr_pin_en = wr_go && reg_hit(awaddr_reg, aesr_pkg::OFF_PIN_EN) && wstrb_reg[0];
  assign wr_mask = wr_go && reg_hit(awaddr_reg, aesr_pkg::OFF_IRQ_MASK) && wstrb_reg[0];
  assign wr_mapped = reg_hit(awaddr_reg, aesr_pkg::OFF_PIN_EN) || reg_hit(awaddr_reg, aesr_pkg::OFF_IRQ_MASK) ||
                     reg_hit(awaddr_reg, aesr_pkg::OFF_IRQ_STATUS) || reg_hit(awaddr_reg, aesr_pkg::OFF_POSITION) ||
                     reg_hit(awaddr_reg, aesr_pkg::OFF_LINK_STATE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= aesr_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? aesr_pkg::RESP_OKAY : aesr_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_en_reg <= aesr_pkg::PIN_EN_RESET;
      mask_reg <= aesr_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_pin_en) begin
        pin_en_reg <= wdata_reg[aesr_pkg::PIN_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= wdata_reg[aesr_pkg::EVT_W-1:0];
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path and interrupt status

  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [aesr_pkg::DATA_W-1:0] rdata_reg;
  logic [aesr_pkg::EVT_W-1:0] status_reg;
  wire ar_fire;
  wire rd_status;
  wire [aesr_pkg::EVT_W-1:0] events;
  wire [aesr_pkg::EVT_W-1:0] status_next;
  wire [aesr_pkg::DATA_W-1:0] link_state;
  wire [aesr_pkg::DATA_W-1:0] rd_mux;
  wire rd_mapped;

  assign s_axi_arready = !rvalid_reg;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_status = ar_fire && reg_hit(s_axi_araddr, aesr_pkg::OFF_IRQ_STATUS);

  assign events = {snapshot_evt, extra_clk_evt, alarm_rise_evt, word_done_evt};
  // A new event in the clearing cycle stays set
  assign status_next = (status_reg & ~{aesr_pkg::EVT_W{rd_status}}) | events;

  assign link_state = {16'h0000, ctl_eff[aesr_pkg::PIN_PROBE], calib_s, factory_clk_s, light_alarm_reg,
                       load_mode, sclk_lvl, serial_data_out, 4'h0, bit_cnt_reg};
  assign rd_mux = reg_hit(s_axi_araddr, aesr_pkg::OFF_PIN_EN) ? {26'h000_0000, pin_en_reg} :
                  reg_hit(s_axi_araddr, aesr_pkg::OFF_IRQ_STATUS) ? {28'h000_0000, status_reg} :
                  reg_hit(s_axi_araddr, aesr_pkg::OFF_IRQ_MASK) ? {28'h000_0000, mask_reg} :
                  reg_hit(s_axi_araddr, aesr_pkg::OFF_POSITION) ? {16'h0000, shreg_reg} :
                  reg_hit(s_axi_araddr, aesr_pkg::OFF_LINK_STATE) ? link_state : 32'h0000_0000;
  assign rd_mapped = reg_hit(s_axi_araddr, aesr_pkg::OFF_PIN_EN) || reg_hit(s_axi_araddr, aesr_pkg::OFF_IRQ_STATUS) ||
                     reg_hit(s_axi_araddr, aesr_pkg::OFF_IRQ_MASK) || reg_hit(s_axi_araddr, aesr_pkg::OFF_POSITION) ||
                     reg_hit(s_axi_araddr, aesr_pkg::OFF_LINK_STATE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= aesr_pkg::RESP_OKAY;
      rdata_reg <= '0;
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_mapped ? aesr_pkg::RESP_OKAY : aesr_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign irq = |(status_reg & mask_reg);

endmodule
